// *** sim/conv_regs_props.sv ***
// checker for alert latch, image copy, blanking and acknowledge timing
`timescale 1ns/1ps
`default_nettype none
module conv_regs_props #(
   parameter int BLANK_LONG_CYCLES = 40,
   parameter int BLANK_SHORT_CYCLES = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic o_sda_oe,
   input wire logic [7:0] i_image_misc_control,
   input wire logic i_output_voltage_event,
   input wire logic i_output_overcurrent_fault_event,
   input wire logic i_current_power_warning_event,
   input wire logic i_overcurrent_recovery_event,
   input wire logic i_spare_event,
   input wire logic i_thermal_event,
   input wire logic i_power_good_off_event,
   input wire logic i_ground_short_event,
   input wire logic i_unclassified_event,
   input wire logic i_power_good_flag_n,
   input wire logic i_alert_clear,
   input wire logic i_current_limit_hit,
   input wire logic o_alert_output_pin,
   input wire logic o_constant_current_regulation,
   input wire logic o_switch_node_edge_speed,
   input wire logic o_current_limit_entry_blanking,
   input wire logic [4:0] o_target_addr
);
   logic flag_q;
   logic cause;
   int lim;
   logic [7:0] hit_cnt;
   logic [7:0] next_hit_cnt;
   assign cause = i_output_voltage_event | i_output_overcurrent_fault_event
      | i_current_power_warning_event | i_overcurrent_recovery_event | i_spare_event
      | i_thermal_event | i_power_good_off_event | i_ground_short_event
      | i_unclassified_event | (flag_q ^ i_power_good_flag_n);
   assign lim = o_current_limit_entry_blanking ? BLANK_SHORT_CYCLES : BLANK_LONG_CYCLES;
   // saturating count of consecutive limit-hit cycles
   always_comb begin
      next_hit_cnt = hit_cnt;
      if (!i_current_limit_hit) begin
         next_hit_cnt = 8'h00;
      end else if (hit_cnt != 8'hFF) begin
         next_hit_cnt = hit_cnt + 8'h01;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      flag_q <= i_power_good_flag_n;
      hit_cnt <= next_hit_cnt;
   end
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   reset_quiet_a: assert property ($fell(i_rst) |-> !o_alert_output_pin && !o_sda_oe
      && !o_constant_current_regulation ##1 !o_alert_output_pin) else $error("busy after reset");
   image_addr_a: assert property ($fell(i_rst) |=> o_target_addr == i_image_misc_control[4:0])
      else $error("target address not taken from image");
   image_modes_a: assert property ($fell(i_rst) |=>
      {o_current_limit_entry_blanking, o_switch_node_edge_speed} == i_image_misc_control[6:5])
      else $error("mode bits not taken from image");
   alert_hold_a: assert property (o_alert_output_pin && !i_alert_clear |=> o_alert_output_pin)
      else $error("alert dropped without clear");
   alert_clear_a: assert property (i_alert_clear && !cause && !$past(cause)
      |=> !o_alert_output_pin) else $error("alert survived clear");
   alert_cause_a: assert property ($rose(o_alert_output_pin) |-> $past(cause)
      || $past(cause, 2)) else $error("alert without event");
   pg_good_a: assert property ($fell(i_power_good_flag_n) |-> ##[1:3] o_alert_output_pin)
      else $error("no alert on power good");
   cc_release_a: assert property (!i_current_limit_hit [*5] |-> !o_constant_current_regulation)
      else $error("regulation held after release");
   cc_early_a: assert property ($rose(o_constant_current_regulation) |-> hit_cnt >= lim)
      else $error("regulation before blanking ended");
   cc_late_a: assert property (hit_cnt == lim + 4 |-> o_constant_current_regulation)
      else $error("regulation late");
   ack_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("data drive changed with clock high");
endmodule
bind converter_alert_mask_config_regs conv_regs_props #(.BLANK_LONG_CYCLES(BLANK_LONG_CYCLES),
   .BLANK_SHORT_CYCLES(BLANK_SHORT_CYCLES)) props_u (.*);
`default_nettype wire

// *** sim/i2c_ctrl_model.sv ***
// bus controller model: start, stop and byte transfers on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
   input wire logic i_sys_clk,
   input wire logic i_sda_oe,
   output logic o_scl,
   output logic o_sda
);
   logic drive_low;
   // open-drain data line with pull-up, either side pulls low
   assign o_sda = !(drive_low || i_sda_oe);
   initial begin
      o_scl = 1'b1;
      drive_low = 1'b0;
   end
   task automatic gap();
      repeat (5) @(posedge i_sys_clk);
      #1;
   endtask
   // also serves as repeated start when the clock line is low
   task automatic start();
      drive_low = 1'b0;
      gap();
      o_scl = 1'b1;
      gap();
      drive_low = 1'b1;
      gap();
      o_scl = 1'b0;
      gap();
   endtask
   task automatic stop();
      drive_low = 1'b1;
      gap();
      o_scl = 1'b1;
      gap();
      drive_low = 1'b0;
      gap();
   endtask
   task automatic bit_io(input logic b, output logic s);
      drive_low = !b;
      gap();
      o_scl = 1'b1;
      gap();
      s = o_sda;
      o_scl = 1'b0;
      gap();
   endtask
   // msb first; send all ones to read, ack_bit 1 leaves the ninth bit released
   task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q,
      output logic nak);
      for (int k = 7; k >= 0; k--) begin
         bit_io(d[k], q[k]);
      end
      bit_io(ack_bit, nak);
   endtask
endmodule
`default_nettype wire

// *** sim/test_converter_alert_mask_config_regs.sv ***
// randomised bench for the converter register bank over the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module test_converter_alert_mask_config_regs;
   localparam int SHORT = 8;
   localparam int LONG = 40;
   localparam logic [7:0] MISC = conv_regs_pkg::MISC_CONTROL_FOUR_ADDR;
   localparam logic [7:0] MASK = conv_regs_pkg::ALERT_EVENT_MASK_ADDR;
   localparam int MB [9] = '{0, 1, 3, 4, 5, 6, 6, 6, 7};
   logic i_sys_clk, i_rst, i_alert_clear, i_current_limit_hit, i_power_good_flag_n;
   logic [7:0] i_image_misc_control, i_image_alert_mask, i_image_config_code, i_image_revision;
   logic [8:0] ev;
   wire i_scl, i_sda, o_sda, o_sda_oe, o_alert_output_pin, o_constant_current_regulation;
   wire o_switch_node_edge_speed, o_current_limit_entry_blanking;
   wire [4:0] o_target_addr;
   wire i_output_voltage_event, i_output_overcurrent_fault_event, i_current_power_warning_event;
   wire i_overcurrent_recovery_event, i_spare_event, i_thermal_event, i_power_good_off_event;
   wire i_ground_short_event, i_unclassified_event;
   logic [31:0] seed = 32'h0000001A;
   logic [6:0] taddr;
   int bad_count, n_tests, cycles;
   assign {i_output_voltage_event, i_output_overcurrent_fault_event, i_current_power_warning_event,
      i_overcurrent_recovery_event, i_spare_event, i_thermal_event, i_power_good_off_event,
      i_ground_short_event, i_unclassified_event} = ev;
   converter_alert_mask_config_regs #(.BLANK_LONG_CYCLES(LONG), .BLANK_SHORT_CYCLES(SHORT))
      dut_u (.*);
   i2c_ctrl_model ctrl_u (.i_sys_clk(i_sys_clk), .i_sda_oe(o_sda_oe), .o_scl(i_scl), .o_sda(i_sda));
   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   function automatic logic [7:0] rnd8();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [7:0] alert_exp(input logic [7:0] m, input int i);
      return {7'h00, !m[MB[i]]};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic clr();
      i_alert_clear = 1'b1;
      tick(1);
      i_alert_clear = 1'b0;
      tick(2);
      check({7'h00, o_alert_output_pin}, 8'h00);
   endtask
   // rd reads back through a repeated start; a misc write moves the target address
   task automatic xact(input logic rd, input logic [7:0] p, input logic [7:0] d,
      output logic [7:0] q);
      logic n;
      ctrl_u.start();
      ctrl_u.xfer({taddr, 1'b0}, 1'b1, q, n);
      check({7'h00, n}, 8'h00);
      ctrl_u.xfer(p, 1'b1, q, n);
      if (rd) begin
         ctrl_u.start();
         ctrl_u.xfer({taddr, 1'b1}, 1'b1, q, n);
         ctrl_u.xfer(8'hFF, 1'b1, q, n);
      end else begin
         ctrl_u.xfer(d, 1'b1, q, n);
         taddr = (p == MISC) ? {1'b1, d[4:0], 1'b1} : taddr;
      end
      ctrl_u.stop();
   endtask
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      logic [7:0] d;
      logic [7:0] v;
      logic [7:0] w;
      logic [7:0] q;
      logic n;
      i_rst = 1'b1;
      ev = 9'h000;
      i_alert_clear = 1'b0;
      i_current_limit_hit = 1'b0;
      i_power_good_flag_n = 1'b1;
      i_image_misc_control = rnd8();
      i_image_alert_mask = rnd8();
      i_image_config_code = rnd8();
      i_image_revision = rnd8();
      tick(16);
      i_rst = 1'b0;
      taddr = {1'b1, i_image_misc_control[4:0], 1'b1};
      tick(3);
      for (int k = 0; k < 4; k++) begin
         xact(1'b1, MISC + k[7:0] + ((k > 0) ? 8'h03 : 8'h00), 8'h00, d);
         v = (k == 0) ? i_image_misc_control & 8'h7F : (k == 1) ? i_image_alert_mask
            : (k == 2) ? i_image_config_code : i_image_revision;
         check(d, v);
      end
      $display("test image readback done");
      for (int k = 0; k < 6; k++) begin
         v = (k == 0) ? 8'hFF : rnd8();
         xact(1'b0, (k < 4) ? MISC : MISC + 8'h01 + k[7:0], v, q);
         d = {1'b0, o_current_limit_entry_blanking, o_switch_node_edge_speed, o_target_addr};
         // code and revision writes must leave the misc outputs alone
         w = (k < 4) ? v & 8'h7F : w;
         check(d, w);
         xact(1'b1, (k < 4) ? MISC : MISC + 8'h01 + k[7:0], 8'h00, d);
         check(d, (k < 4) ? v & 8'h7F : v);
      end
      ctrl_u.start();
      ctrl_u.xfer({taddr ^ 7'h04, 1'b0}, 1'b1, q, n);
      ctrl_u.stop();
      check({7'h00, n}, 8'h01);
      xact(1'b1, 8'hD5, 8'h00, d);
      check(d, 8'h00);
      check({7'h00, o_sda}, 8'h00);
      $display("test register access done");
      for (int i = 0; i < 9; i++) begin
         for (int m = 0; m < 2; m++) begin
            v = rnd8();
            v[MB[i]] = m[0];
            xact(1'b0, MASK, v, q);
            ev = 9'h001 << i;
            tick(1);
            ev = 9'h000;
            tick(2);
            check({7'h00, o_alert_output_pin}, alert_exp(v, i));
            clr();
         end
      end
      xact(1'b1, MASK, 8'h00, d);
      check(d, v);
      for (int m = 0; m < 2; m++) begin
         xact(1'b0, MASK, (m == 1) ? 8'h04 : 8'h00, q);
         i_power_good_flag_n = 1'b0;
         tick(4);
         check({7'h00, o_alert_output_pin}, 8'h01);
         clr();
         i_power_good_flag_n = 1'b1;
         tick(4);
         check({7'h00, o_alert_output_pin}, {7'h00, m == 0});
         clr();
      end
      $display("test alert masking done");
      for (int b = 0; b < 2; b++) begin
         xact(1'b0, MISC, {1'b0, b[0], 1'b1, taddr[5:1]}, q);
         i_current_limit_hit = 1'b1;
         tick(((b == 1) ? SHORT : LONG) - 1);
         check({7'h00, o_constant_current_regulation}, 8'h00);
         tick(7);
         check({7'h00, o_constant_current_regulation}, 8'h01);
         i_current_limit_hit = 1'b0;
         tick(6);
         check({7'h00, o_constant_current_regulation}, 8'h00);
      end
      $display("test blanking done");
      conclude();
   end
endmodule
`default_nettype wire

// *** verilog/conv_regs_pkg.sv ***
// constants for the converter alert, mask and configuration register bank
package conv_regs_pkg;
   localparam logic [7:0] MISC_CONTROL_FOUR_ADDR = 8'hD4;
   localparam logic [7:0] ALERT_EVENT_MASK_ADDR = 8'hD8;
   localparam logic [7:0] FACTORY_CONFIG_CODE_ADDR = 8'hD9;
   localparam logic [7:0] FACTORY_IMAGE_REVISION_ADDR = 8'hDA;
   // misc control fields
   localparam int MISC_SPARE_BIT = 7;
   localparam int MISC_BLANK_BIT = 6;
   localparam int MISC_EDGE_BIT = 5;
   localparam int MISC_ADDR_MSB = 4;
   localparam int MISC_ADDR_LSB = 0;
   localparam logic [7:0] MISC_WRITE_KEEP = 8'h7F;
   // mask fields
   localparam int MASK_VOUT_BIT = 7;
   localparam int MASK_IOUT_BIT = 6;
   localparam int MASK_SPARE_BIT = 5;
   localparam int MASK_TEMP_BIT = 4;
   localparam int MASK_PG_OFF_BIT = 3;
   localparam int MASK_PG_EDGE_BIT = 2;
   localparam int MASK_GND_BIT = 1;
   localparam int MASK_UNKNOWN_BIT = 0;
   // values held while reset is asserted, before the image is copied
   localparam logic [7:0] MISC_RESET = 8'h67;
   localparam logic [7:0] MASK_RESET = 8'hBF;
   localparam logic [7:0] CODE_RESET = 8'h00;
   localparam logic [7:0] REV_RESET = 8'h00;
   // fixed target address bits around the programmable field
   localparam logic ADDR_TOP_BIT = 1'b1;
   localparam logic ADDR_BOTTOM_BIT = 1'b1;
   // blanking times
   localparam int CLK_MHZ = 125;
   localparam int BLANK_LONG_MS = 5;
   localparam int BLANK_SHORT_US = 400;
   localparam int BLANK_LONG_CYCLES = BLANK_LONG_MS * 1000 * CLK_MHZ;
   localparam int BLANK_SHORT_CYCLES = BLANK_SHORT_US * CLK_MHZ;
   localparam int BLANK_CNT_W = 20;
endpackage

// *** verilog/converter_alert_mask_config_regs.sv ***
// register bank with alert masking, blanking timer and image read-back
`timescale 1ns/1ps
`default_nettype none
module converter_alert_mask_config_regs #(
   parameter int BLANK_LONG_CYCLES = conv_regs_pkg::BLANK_LONG_CYCLES,
   parameter int BLANK_SHORT_CYCLES = conv_regs_pkg::BLANK_SHORT_CYCLES
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   input wire logic [7:0] i_image_misc_control,
   input wire logic [7:0] i_image_alert_mask,
   input wire logic [7:0] i_image_config_code,
   input wire logic [7:0] i_image_revision,
   input wire logic i_output_voltage_event,
   input wire logic i_output_overcurrent_fault_event,
   input wire logic i_current_power_warning_event,
   input wire logic i_overcurrent_recovery_event,
   input wire logic i_spare_event,
   input wire logic i_thermal_event,
   input wire logic i_power_good_off_event,
   input wire logic i_ground_short_event,
   input wire logic i_unclassified_event,
   input wire logic i_power_good_flag_n,
   input wire logic i_alert_clear,
   input wire logic i_current_limit_hit,
   output logic o_alert_output_pin,
   output logic o_constant_current_regulation,
   output logic o_switch_node_edge_speed,
   output logic o_current_limit_entry_blanking,
   output logic [4:0] o_target_addr
);
   serial_byte_if bus ();

   logic [7:0] misc_control_four, next_misc_control_four;
   logic [7:0] alert_event_mask, next_alert_event_mask;
   logic [7:0] factory_config_code, next_factory_config_code;
   logic [7:0] factory_image_revision, next_factory_image_revision;
   logic [7:0] pointer, next_pointer;
   logic load_pending;
   logic pg_prev, next_pg_prev;
   logic alert, next_alert;
   logic hit_meta, hit_sync;
   logic [conv_regs_pkg::BLANK_CNT_W-1:0] blank_cnt, next_blank_cnt, blank_limit;
   logic cc_on, next_cc_on;
   logic pg_went_bad, pg_went_good, alert_set;

   serial_target u_target (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_sda_oe(o_sda_oe),
      .bus(bus)
   );

   function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] misc,
      input logic [7:0] mask, input logic [7:0] code, input logic [7:0] rev);
      logic [7:0] val;
      val = 8'h00;
      if (addr == conv_regs_pkg::MISC_CONTROL_FOUR_ADDR) begin
         val = misc;
      end else if (addr == conv_regs_pkg::ALERT_EVENT_MASK_ADDR) begin
         val = mask;
      end else if (addr == conv_regs_pkg::FACTORY_CONFIG_CODE_ADDR) begin
         val = code;
      end else if (addr == conv_regs_pkg::FACTORY_IMAGE_REVISION_ADDR) begin
         val = rev;
      end
      return val;
   endfunction

   assign bus.rd_data = read_mux(pointer, misc_control_four, alert_event_mask,
      factory_config_code, factory_image_revision);
   assign bus.target_addr =
      misc_control_four[conv_regs_pkg::MISC_ADDR_MSB:conv_regs_pkg::MISC_ADDR_LSB];

   // register writes and image copy
   always_comb begin
      next_misc_control_four = misc_control_four;
      next_alert_event_mask = alert_event_mask;
      next_factory_config_code = factory_config_code;
      next_factory_image_revision = factory_image_revision;
      next_pointer = pointer;
      if (load_pending) begin
         next_misc_control_four = i_image_misc_control & conv_regs_pkg::MISC_WRITE_KEEP;
         next_alert_event_mask = i_image_alert_mask;
         next_factory_config_code = i_image_config_code;
         next_factory_image_revision = i_image_revision;
      end else if (bus.wr_valid && bus.wr_first) begin
         next_pointer = bus.wr_data;
      end else if (bus.wr_valid) begin
         if (pointer == conv_regs_pkg::MISC_CONTROL_FOUR_ADDR) begin
            next_misc_control_four = bus.wr_data & conv_regs_pkg::MISC_WRITE_KEEP;
         end else if (pointer == conv_regs_pkg::ALERT_EVENT_MASK_ADDR) begin
            next_alert_event_mask = bus.wr_data;
         end else if (pointer == conv_regs_pkg::FACTORY_CONFIG_CODE_ADDR) begin
            next_factory_config_code = bus.wr_data;
         end else if (pointer == conv_regs_pkg::FACTORY_IMAGE_REVISION_ADDR) begin
            next_factory_image_revision = bus.wr_data;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         misc_control_four <= conv_regs_pkg::MISC_RESET;
         alert_event_mask <= conv_regs_pkg::MASK_RESET;
         factory_config_code <= conv_regs_pkg::CODE_RESET;
         factory_image_revision <= conv_regs_pkg::REV_RESET;
         pointer <= 8'h00;
         load_pending <= 1'b1;
      end else begin
         misc_control_four <= next_misc_control_four;
         alert_event_mask <= next_alert_event_mask;
         factory_config_code <= next_factory_config_code;
         factory_image_revision <= next_factory_image_revision;
         pointer <= next_pointer;
         load_pending <= 1'b0;
      end
   end

   // alert gating: mask acts on the alert pin latch only
   assign pg_went_bad = i_power_good_flag_n & ~pg_prev;
   assign pg_went_good = ~i_power_good_flag_n & pg_prev;
   always_comb begin
      alert_set = 1'b0;
      alert_set = alert_set | (i_output_voltage_event
         & ~alert_event_mask[conv_regs_pkg::MASK_VOUT_BIT]);
      alert_set = alert_set | ((i_output_overcurrent_fault_event | i_current_power_warning_event
         | i_overcurrent_recovery_event) & ~alert_event_mask[conv_regs_pkg::MASK_IOUT_BIT]);
      alert_set = alert_set | (i_spare_event
         & ~alert_event_mask[conv_regs_pkg::MASK_SPARE_BIT]);
      alert_set = alert_set | (i_thermal_event
         & ~alert_event_mask[conv_regs_pkg::MASK_TEMP_BIT]);
      alert_set = alert_set | (i_power_good_off_event
         & ~alert_event_mask[conv_regs_pkg::MASK_PG_OFF_BIT]);
      alert_set = alert_set | pg_went_good
         | (pg_went_bad & ~alert_event_mask[conv_regs_pkg::MASK_PG_EDGE_BIT]);
      alert_set = alert_set | (i_ground_short_event
         & ~alert_event_mask[conv_regs_pkg::MASK_GND_BIT]);
      alert_set = alert_set | (i_unclassified_event
         & ~alert_event_mask[conv_regs_pkg::MASK_UNKNOWN_BIT]);
      if (load_pending) begin
         alert_set = 1'b0;
      end
      next_pg_prev = i_power_good_flag_n;
      // set wins over a clear in the same cycle
      next_alert = alert_set | (alert & ~i_alert_clear);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         pg_prev <= 1'b1;
         alert <= 1'b0;
      end else begin
         pg_prev <= next_pg_prev;
         alert <= next_alert;
      end
   end

   // blanking before constant current regulation
   assign blank_limit = misc_control_four[conv_regs_pkg::MISC_BLANK_BIT] ?
      conv_regs_pkg::BLANK_CNT_W'(BLANK_SHORT_CYCLES - 1) :
      conv_regs_pkg::BLANK_CNT_W'(BLANK_LONG_CYCLES - 1);
   always_comb begin
      next_blank_cnt = blank_cnt;
      next_cc_on = cc_on;
      if (!hit_sync) begin
         next_blank_cnt = '0;
         next_cc_on = 1'b0;
      end else if (blank_cnt >= blank_limit) begin
         next_cc_on = 1'b1;
      end else begin
         next_blank_cnt = blank_cnt + 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         hit_meta <= 1'b0;
         hit_sync <= 1'b0;
         blank_cnt <= '0;
         cc_on <= 1'b0;
      end else begin
         hit_meta <= i_current_limit_hit;
         hit_sync <= hit_meta;
         blank_cnt <= next_blank_cnt;
         cc_on <= next_cc_on;
      end
   end

   // outputs straight from flops, except o_sda which is tied low
   assign o_sda = 1'b0;
   assign o_alert_output_pin = alert;
   assign o_constant_current_regulation = cc_on;
   assign o_switch_node_edge_speed = misc_control_four[conv_regs_pkg::MISC_EDGE_BIT];
   assign o_current_limit_entry_blanking = misc_control_four[conv_regs_pkg::MISC_BLANK_BIT];
   assign o_target_addr = bus.target_addr;
endmodule
`default_nettype wire

// *** verilog/serial_byte_if.sv ***
// byte-level carrier between the serial target engine and the register bank
`timescale 1ns/1ps
`default_nettype none
interface serial_byte_if;
   logic [4:0] target_addr;
   logic wr_valid;
   logic wr_first;
   logic [7:0] wr_data;
   logic rd_req;
   logic [7:0] rd_data;
   modport engine (input target_addr, input rd_data, output wr_valid, output wr_first,
      output wr_data, output rd_req);
   modport bank (output target_addr, output rd_data, input wr_valid, input wr_first,
      input wr_data, input rd_req);
endinterface
`default_nettype wire

// *** verilog/serial_target.sv ***
// two-wire serial target engine: start/stop, address match, byte shifting
`timescale 1ns/1ps
`default_nettype none
module serial_target (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_oe,
   serial_byte_if.engine bus
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b011,
      ST_WRITE = 3'b010,
      ST_WRITE_ACK = 3'b110,
      ST_READ = 3'b111,
      ST_READ_ACK = 3'b101
   } tgt_state_t;

   logic scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev;
   tgt_state_t state, next_state;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] shreg, next_shreg;
   logic sda_oe, next_sda_oe;
   logic is_read, next_is_read;
   logic first, next_first;
   logic nacked, next_nacked;
   logic wr_valid, next_wr_valid;
   logic rd_req, next_rd_req;
   logic scl_rise, scl_fall, start_seen, stop_seen;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_meta <= i_scl;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= i_sda;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
      end
   end

   assign scl_rise = scl_sync & ~scl_prev;
   assign scl_fall = ~scl_sync & scl_prev;
   assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
   assign stop_seen = scl_sync & scl_prev & ~sda_prev & sda_sync;

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_sda_oe = sda_oe;
      next_is_read = is_read;
      next_first = first;
      next_nacked = nacked;
      next_wr_valid = 1'b0;
      next_rd_req = 1'b0;
      if (start_seen) begin
         next_state = ST_ADDR;
         next_bit_cnt = 4'h0;
         next_sda_oe = 1'b0;
      end else if (stop_seen) begin
         next_state = ST_IDLE;
         next_sda_oe = 1'b0;
      end else begin
         case (state)
            ST_ADDR, ST_WRITE: begin
               if (scl_rise && bit_cnt != 4'h8) begin
                  next_shreg = {shreg[6:0], sda_sync};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  if (state == ST_WRITE) begin
                     next_wr_valid = 1'b1;
                     next_sda_oe = 1'b1;
                     next_state = ST_WRITE_ACK;
                  end else if (shreg[7:1] == {ADDR_TOP(), bus.target_addr, ADDR_BOT()}) begin
                     next_is_read = shreg[0];
                     next_sda_oe = 1'b1;
                     next_state = ST_ADDR_ACK;
                  end else begin
                     next_state = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK, ST_WRITE_ACK: begin
               if (scl_fall) begin
                  next_bit_cnt = 4'h0;
                  next_first = (state == ST_ADDR_ACK);
                  if (state == ST_WRITE_ACK) begin
                     next_first = 1'b0;
                  end
                  if (state == ST_ADDR_ACK && is_read) begin
                     next_rd_req = 1'b1;
                     next_shreg = bus.rd_data;
                     next_sda_oe = ~bus.rd_data[7];
                     next_state = ST_READ;
                  end else begin
                     next_sda_oe = 1'b0;
                     next_state = ST_WRITE;
                  end
               end
            end
            ST_READ: begin
               if (scl_rise) begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  next_sda_oe = 1'b0;
                  next_state = ST_READ_ACK;
               end else if (scl_fall) begin
                  next_shreg = {shreg[6:0], 1'b0};
                  next_sda_oe = ~shreg[6];
               end
            end
            ST_READ_ACK: begin
               if (scl_rise) begin
                  next_nacked = sda_sync;
               end else if (scl_fall && nacked) begin
                  next_state = ST_IDLE;
               end else if (scl_fall) begin
                  next_rd_req = 1'b1;
                  next_shreg = bus.rd_data;
                  next_sda_oe = ~bus.rd_data[7];
                  next_bit_cnt = 4'h0;
                  next_state = ST_READ;
               end
            end
            default: begin
               next_sda_oe = 1'b0;
            end
         endcase
      end
   end

   function automatic logic ADDR_TOP();
      return conv_regs_pkg::ADDR_TOP_BIT;
   endfunction

   function automatic logic ADDR_BOT();
      return conv_regs_pkg::ADDR_BOTTOM_BIT;
   endfunction

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         sda_oe <= 1'b0;
         is_read <= 1'b0;
         first <= 1'b0;
         nacked <= 1'b0;
         wr_valid <= 1'b0;
         rd_req <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         sda_oe <= next_sda_oe;
         is_read <= next_is_read;
         first <= next_first;
         nacked <= next_nacked;
         wr_valid <= next_wr_valid;
         rd_req <= next_rd_req;
      end
   end

   assign o_sda_oe = sda_oe;
   assign bus.wr_valid = wr_valid;
   assign bus.wr_first = first;
   assign bus.wr_data = shreg;
   assign bus.rd_req = rd_req;
endmodule
`default_nettype wire
